// File: hdl/slt_pkg.sv
// Constants and types for the speed command and speed loop tuning block
// What this block does
// RULE1 - Speed command scales linearly with reference minus ground; 10 V gives full scale.
// RULE2 - Full-scale speed is in r/min, 0 to 50000, defaults to rated speed.
// RULE3 - Zero-speed mode forces first command to zero; plain mode uses analog input.
// RULE4 - While enabled, the two select inputs pick the active speed command.
// RULE5 - Tuning mode: 0 manual, 1 auto continuous, 2 semi-auto; defaults to 0.
// RULE6 - Manual mode uses only user gains; all automatic adjustment is off.
// RULE7 - Leaving auto or semi-auto for manual stores estimated inertia and sets gains.
// RULE8 - Auto estimates continuously, saves inertia every 30 minutes, uses stiffness setting.
// RULE9 - Auto to manual copies auto position, proportional and integral gains.
// RULE10 - Semi-auto to manual also copies low-pass time and disturbance gain.
// RULE11 - Operator writes a suitable inertia ratio before entering auto or semi-auto.
// RULE12 - Semi-auto sets stable flag, stops estimating, saves inertia; entering restarts it.
// RULE13 - Semi-auto inertia out of range clears stable flag and resumes estimating.
// RULE14 - Proportional speed gain is 16-bit rad/s, 0 to 8191, defaults to 500.
// RULE15 - Integral speed gain is 16-bit rad/s, 0 to 1023, defaults to 100.
// RULE16 - Feed-forward speed gain is 16-bit percent, 0 to 100, defaults to 0.
// RULE17 - Current command is Kp times error plus Ki times sum plus feed-forward share.
package slt_pkg;

  typedef enum logic [1:0] {TUNE_MANUAL, TUNE_AUTO, TUNE_SEMI} slt_tune_e;

  // Parameter offsets
  localparam logic [15:0] OFS_FULL_SCALE = 16'h0150;
  localparam logic [15:0] OFS_PROP_GAIN  = 16'h0208;
  localparam logic [15:0] OFS_INTEG_GAIN = 16'h020c;
  localparam logic [15:0] OFS_TUNE_MODE  = 16'h0240;
  localparam logic [15:0] OFS_INERTIA    = 16'h0300;
  localparam logic [15:0] OFS_STIFFNESS  = 16'h0304;
  localparam logic [15:0] OFS_STABLE     = 16'h0308;
  localparam logic [15:0] OFS_POS_GAIN   = 16'h030c;
  localparam logic [15:0] OFS_LOWPASS    = 16'h0310;
  localparam logic [15:0] OFS_DISTURB    = 16'h0314;
  localparam logic [15:0] OFS_FF_GAIN    = 16'h0318;
  localparam logic [15:0] OFS_PRESET0    = 16'h0320;

  // Limits, values after reset and values set on leaving semi-auto
  localparam logic [31:0] FULL_SCALE_MAX = 32'h0000_c350;
  localparam logic [15:0] PROP_GAIN_MAX  = 16'h1fff;
  localparam logic [15:0] PROP_GAIN_RST  = 16'h01f4;
  localparam logic [15:0] INTEG_GAIN_MAX = 16'h03ff;
  localparam logic [15:0] INTEG_GAIN_RST = 16'h0064;
  localparam logic [15:0] FF_GAIN_MAX    = 16'h0064;
  localparam logic [15:0] FF_GAIN_RST    = 16'h0000;
  localparam logic [15:0] INERTIA_RST    = 16'h000a;
  localparam logic [15:0] STIFFNESS_RST  = 16'h0050;
  localparam logic [15:0] POS_GAIN_RST   = 16'h0023;
  localparam logic [15:0] LOWPASS_RST    = 16'h0002;
  localparam logic [15:0] DISTURB_RST    = 16'h0000;
  localparam logic [15:0] SEMI_LOWPASS   = 16'h0005;
  localparam logic [15:0] SEMI_DISTURB   = 16'h0032;

  // Scaling and timing
  localparam longint VOLT_FULL_MV    = 10000;
  localparam longint PCT_FULL        = 100;
  localparam int     GAIN_SHIFT      = 10;
  localparam longint CLK_PERIOD_NS   = 4;
  localparam longint SAVE_PERIOD_MIN = 30;
  localparam longint SAVE_PERIOD_CYC = SAVE_PERIOD_MIN * 60 * 1000000000 / CLK_PERIOD_NS;
  localparam longint CTRL_PERIOD_NS  = 100000;
  localparam longint CTRL_DIV_CYC    = CTRL_PERIOD_NS / CLK_PERIOD_NS;

endpackage : slt_pkg

// File: hdl/slt_speed_loop.sv
// Speed command selection, analog scaling, gain tuning and speed PI loop
`timescale 1ns/1ns
module slt_speed_loop #(
  parameter int     ADC_W           = 16,
  parameter int     RATED_SPEED     = 3000,
  parameter longint SAVE_PERIOD_CYC = slt_pkg::SAVE_PERIOD_CYC,
  parameter longint CTRL_DIV        = slt_pkg::CTRL_DIV_CYC
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  // Analog reference, in millivolts
  input  wire logic signed [ADC_W-1:0] speed_ref_mv_i,
  input  wire logic signed [ADC_W-1:0] analog_ground_input_i,
  // Mode and select inputs
  input  wire logic                    zero_command_speed_mode_i,
  input  wire logic                    speed_select_bit0_i,
  input  wire logic                    speed_select_bit1_i,
  input  wire logic                    drive_enable_i,
  // Motor speed feedback
  input  wire logic signed [31:0]      speed_fb_i,
  // Inertia estimator
  input  wire logic [15:0]             inertia_estimate_i,
  input  wire logic                    inertia_settled_i,
  input  wire logic                    inertia_out_of_range_i,
  output logic                         estimate_run_o,
  // Parameter access
  input  wire logic                    param_wr_i,
  input  wire logic                    param_rd_i,
  input  wire logic [15:0]             param_addr_i,
  input  wire logic [31:0]             param_wdata_i,
  output logic [31:0]                  param_rdata_o,
  // Command outputs
  output logic signed [31:0]           first_speed_command_o,
  output logic signed [31:0]           speed_cmd_o,
  output logic signed [31:0]           current_cmd_o
);

  logic [31:0]        full_scale_ff;
  // Gains as last written, or as copied in on leaving auto or semi-auto
  logic [15:0]        prop_gain_ff;
  logic [15:0]        integ_gain_ff;
  logic [15:0]        ff_gain_ff;
  logic [15:0]        inertia_ff, stiff_ff, pos_ff, lowpass_ff, disturb_ff;
  logic               stable_ff;
  logic               run_ff;
  logic [1:0]         tune_ff;
  logic [31:0]        preset_ff [3];
  logic [39:0]        save_cnt_ff;
  logic [31:0]        div_cnt_ff;
  logic signed [47:0] acc_ff;
  logic signed [31:0] first_cmd_ff, cmd_ff, cur_ff;
  logic [31:0]        rdata_ff;

  logic               wr_tune, to_manual, to_semi, save_tick, ctrl_tick;
  logic [15:0]        inertia_use, prop_auto, integ_auto, pos_auto;
  logic [15:0]        prop_use, integ_use;
  logic [31:0]        stiff_prod;
  logic signed [63:0] scaled, err, p_term, i_term, ff_term, sum;

  // Writes to the mode field with an out-of-range value are dropped
  assign wr_tune   = param_wr_i && param_addr_i == slt_pkg::OFS_TUNE_MODE
                     && param_wdata_i <= 32'(slt_pkg::TUNE_SEMI); // RULE5
  assign to_manual = wr_tune && param_wdata_i[1:0] == slt_pkg::TUNE_MANUAL
                     && tune_ff != slt_pkg::TUNE_MANUAL;
  assign to_semi   = wr_tune && param_wdata_i[1:0] == slt_pkg::TUNE_SEMI
                     && tune_ff != slt_pkg::TUNE_SEMI;

  // Auto gains follow stiffness scaled by load inertia, except the position gain, which follows stiffness alone
  assign inertia_use = (tune_ff == slt_pkg::TUNE_SEMI && stable_ff) ? inertia_ff
                                                                     : inertia_estimate_i;
  assign stiff_prod  = 32'(64'(stiff_ff) * (64'(inertia_use) + slt_pkg::PCT_FULL)
                           / slt_pkg::PCT_FULL); // RULE8
  // Clamped so a heavy load cannot push the gain past its range
  assign prop_auto   = (stiff_prod > 32'(slt_pkg::PROP_GAIN_MAX)) ? slt_pkg::PROP_GAIN_MAX
                                                                 : stiff_prod[15:0];
  // Integral follows a quarter of the proportional gain
  assign integ_auto  = (prop_auto[15:2] > slt_pkg::INTEG_GAIN_MAX[13:0]) ?
                       slt_pkg::INTEG_GAIN_MAX : {2'h0, prop_auto[15:2]};
  assign pos_auto    = {2'h0, stiff_ff[15:2]};
  assign prop_use    = (tune_ff == slt_pkg::TUNE_MANUAL) ? prop_gain_ff : prop_auto; // RULE6
  assign integ_use   = (tune_ff == slt_pkg::TUNE_MANUAL) ? integ_gain_ff : integ_auto; // RULE6

  // Full-scale and speed gains, clamped to range on write
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      full_scale_ff <= 32'(RATED_SPEED); // RULE2
      prop_gain_ff  <= slt_pkg::PROP_GAIN_RST; // RULE14
      integ_gain_ff <= slt_pkg::INTEG_GAIN_RST; // RULE15
      ff_gain_ff    <= slt_pkg::FF_GAIN_RST; // RULE16
      pos_ff        <= slt_pkg::POS_GAIN_RST;
      lowpass_ff    <= slt_pkg::LOWPASS_RST;
      disturb_ff    <= slt_pkg::DISTURB_RST;
      stiff_ff      <= slt_pkg::STIFFNESS_RST;
    end else if (to_manual) begin
      prop_gain_ff  <= prop_auto; // RULE9
      integ_gain_ff <= integ_auto; // RULE9
      pos_ff <= pos_auto; // RULE7
      if (tune_ff == slt_pkg::TUNE_SEMI) begin
        lowpass_ff <= slt_pkg::SEMI_LOWPASS; // RULE10
        disturb_ff <= slt_pkg::SEMI_DISTURB; // RULE10
      end
    end else if (param_wr_i) begin
      case (param_addr_i)
        slt_pkg::OFS_FULL_SCALE: full_scale_ff <= (param_wdata_i > slt_pkg::FULL_SCALE_MAX) ?
                                   slt_pkg::FULL_SCALE_MAX : param_wdata_i; // RULE2
        slt_pkg::OFS_PROP_GAIN: prop_gain_ff <= (param_wdata_i > 32'(slt_pkg::PROP_GAIN_MAX))
                                   ? slt_pkg::PROP_GAIN_MAX : param_wdata_i[15:0]; // RULE14
        slt_pkg::OFS_INTEG_GAIN: integ_gain_ff <= (param_wdata_i > 32'(slt_pkg::INTEG_GAIN_MAX))
                                   ? slt_pkg::INTEG_GAIN_MAX : param_wdata_i[15:0]; // RULE15
        slt_pkg::OFS_FF_GAIN: ff_gain_ff <= (param_wdata_i > 32'(slt_pkg::FF_GAIN_MAX))
                                   ? slt_pkg::FF_GAIN_MAX : param_wdata_i[15:0]; // RULE16
        slt_pkg::OFS_POS_GAIN:  pos_ff     <= param_wdata_i[15:0];
        slt_pkg::OFS_LOWPASS:   lowpass_ff <= param_wdata_i[15:0];
        slt_pkg::OFS_DISTURB:   disturb_ff <= param_wdata_i[15:0];
        slt_pkg::OFS_STIFFNESS: stiff_ff   <= param_wdata_i[15:0];
        default: begin
        end
      endcase
    end
  end

  // Preset speed commands picked by the select inputs
  for (genvar g = 0; g < 3; g++) begin : g_preset
    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        preset_ff[g] <= 32'h0;
      end else if (param_wr_i && param_addr_i == slt_pkg::OFS_PRESET0 + 16'(4 * g)) begin
        preset_ff[g] <= param_wdata_i;
      end
    end
  end

  // Tuning mode
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tune_ff <= slt_pkg::TUNE_MANUAL; // RULE5
    end else if (wr_tune) begin
      tune_ff <= param_wdata_i[1:0]; // RULE5
    end
  end

  // Estimation run and stable flag
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      run_ff    <= 1'b0;
      stable_ff <= 1'b0;
    end else if (to_semi) begin
      run_ff    <= 1'b1; // RULE12
      stable_ff <= 1'b0; // RULE12
    end else if (wr_tune) begin
      run_ff    <= param_wdata_i[1:0] == slt_pkg::TUNE_AUTO; // RULE6
      stable_ff <= 1'b0;
    end else if (tune_ff == slt_pkg::TUNE_SEMI) begin
      if (inertia_out_of_range_i) begin
        run_ff    <= 1'b1; // RULE13
        stable_ff <= 1'b0; // RULE13
      end else if (run_ff && inertia_settled_i) begin
        run_ff    <= 1'b0; // RULE12
        stable_ff <= 1'b1; // RULE12
      end
    end else if (tune_ff == slt_pkg::TUNE_AUTO) begin
      run_ff <= 1'b1; // RULE8
    end
  end

  // Periodic inertia save in auto mode
  assign save_tick = tune_ff == slt_pkg::TUNE_AUTO && save_cnt_ff == 40'(SAVE_PERIOD_CYC - 1);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      save_cnt_ff <= 40'h0;
    end else if (tune_ff != slt_pkg::TUNE_AUTO || save_tick) begin
      save_cnt_ff <= 40'h0;
    end else begin
      save_cnt_ff <= save_cnt_ff + 40'h1; // RULE8
    end
  end

  // Inertia ratio; an operator write wins over a save in the same cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      inertia_ff <= slt_pkg::INERTIA_RST;
    end else if (param_wr_i && param_addr_i == slt_pkg::OFS_INERTIA) begin
      inertia_ff <= param_wdata_i[15:0]; // RULE11
    end else if (to_manual) begin
      inertia_ff <= inertia_estimate_i; // RULE7
    end else if (save_tick) begin
      inertia_ff <= inertia_estimate_i; // RULE8
    end else if (tune_ff == slt_pkg::TUNE_SEMI && run_ff && inertia_settled_i
                 && !inertia_out_of_range_i) begin
      inertia_ff <= inertia_estimate_i; // RULE12
    end
  end

  // Analog scaling: full scale at 10 V of reference above ground
  assign scaled = (64'(speed_ref_mv_i) - 64'(analog_ground_input_i))
                  * $signed({32'h0, full_scale_ff}) / slt_pkg::VOLT_FULL_MV; // RULE1

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      first_cmd_ff <= 32'sh0;
    end else if (zero_command_speed_mode_i) begin
      first_cmd_ff <= 32'sh0; // RULE3
    end else begin
      // Truncates toward zero; inputs under one step read as zero speed
      first_cmd_ff <= 32'(scaled); // RULE3
    end
  end

  // Active speed command; zero while the drive is off
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_ff <= 32'sh0;
    end else if (!drive_enable_i) begin
      cmd_ff <= 32'sh0;
    end else begin
      // Select pins used as sampled; no debounce in this block
      case ({speed_select_bit1_i, speed_select_bit0_i})
        2'h0:    cmd_ff <= first_cmd_ff; // RULE4
        2'h1:    cmd_ff <= preset_ff[0]; // RULE4
        2'h2:    cmd_ff <= preset_ff[1]; // RULE4
        default: cmd_ff <= preset_ff[2]; // RULE4
      endcase
    end
  end

  // Loop runs at the control rate, not every clock, to bound the integral
  assign ctrl_tick = div_cnt_ff == 32'(CTRL_DIV - 1);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_cnt_ff <= 32'h0;
    end else if (ctrl_tick) begin
      div_cnt_ff <= 32'h0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 32'h1;
    end
  end

  // Wide products so full gain times full error cannot overflow
  assign err     = 64'(cmd_ff) - 64'(speed_fb_i);
  assign p_term  = $signed({48'h0, prop_use}) * err;
  assign i_term  = $signed({48'h0, integ_use}) * 64'(acc_ff);
  assign ff_term = 64'(cmd_ff) * $signed({48'h0, ff_gain_ff}) / slt_pkg::PCT_FULL;
  assign sum     = ((p_term + i_term) >>> slt_pkg::GAIN_SHIFT) + ff_term; // RULE17

  // Integrator cleared while disabled to avoid windup at enable
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      acc_ff <= 48'sh0;
    end else if (!drive_enable_i) begin
      acc_ff <= 48'sh0;
    end else if (ctrl_tick) begin
      acc_ff <= acc_ff + 48'(err); // RULE17
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cur_ff <= 32'sh0;
    end else if (!drive_enable_i) begin
      cur_ff <= 32'sh0;
    end else if (ctrl_tick) begin
      cur_ff <= 32'(sum); // RULE17
    end
  end

  // Read data, registered; unmapped offsets read zero
  // A write in the same cycle is seen only by the next read
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_ff <= 32'h0;
    end else if (param_rd_i) begin
      case (param_addr_i)
        slt_pkg::OFS_FULL_SCALE: rdata_ff <= full_scale_ff;
        slt_pkg::OFS_PROP_GAIN:  rdata_ff <= {16'h0, prop_gain_ff};
        slt_pkg::OFS_INTEG_GAIN: rdata_ff <= {16'h0, integ_gain_ff};
        slt_pkg::OFS_TUNE_MODE:  rdata_ff <= {30'h0, tune_ff};
        slt_pkg::OFS_INERTIA:    rdata_ff <= {16'h0, inertia_ff};
        slt_pkg::OFS_STIFFNESS:  rdata_ff <= {16'h0, stiff_ff};
        slt_pkg::OFS_STABLE:     rdata_ff <= {31'h0, stable_ff};
        slt_pkg::OFS_POS_GAIN:   rdata_ff <= {16'h0, pos_ff};
        slt_pkg::OFS_LOWPASS:    rdata_ff <= {16'h0, lowpass_ff};
        slt_pkg::OFS_DISTURB:    rdata_ff <= {16'h0, disturb_ff};
        slt_pkg::OFS_FF_GAIN:    rdata_ff <= {16'h0, ff_gain_ff};
        slt_pkg::OFS_PRESET0:    rdata_ff <= preset_ff[0];
        slt_pkg::OFS_PRESET0 + 16'h4: rdata_ff <= preset_ff[1];
        slt_pkg::OFS_PRESET0 + 16'h8: rdata_ff <= preset_ff[2];
        default:                 rdata_ff <= 32'h0;
      endcase
    end
  end

  assign estimate_run_o        = run_ff;
  assign param_rdata_o         = rdata_ff;
  assign first_speed_command_o = first_cmd_ff;
  assign speed_cmd_o           = cmd_ff;
  assign current_cmd_o         = cur_ff;

endmodule : slt_speed_loop

// File: verification/slt_ref_src.sv
// Analog reference source and select switches facing the speed loop
`timescale 1ns/1ns
module slt_ref_src (
  // Levels asked for by the bench
  input  wire logic signed [15:0] ref_mv_i,
  input  wire logic signed [15:0] gnd_mv_i,
  input  wire logic [1:0]         sel_i,
  input  wire logic               zero_i,
  // Levels on the drive pins
  output logic signed [15:0]      ref_o,
  output logic signed [15:0]      gnd_o,
  output logic                    sel0_o,
  output logic                    sel1_o,
  output logic                    zero_o
);
  // Source swings at most 10 V positive; negative levels and ground are not limited
  assign ref_o = (ref_mv_i > 16'sd10000) ? 16'sd10000 : ref_mv_i;
  assign gnd_o = gnd_mv_i;
  assign {sel1_o, sel0_o} = sel_i;
  assign zero_o = zero_i;
endmodule : slt_ref_src

// File: verification/slt_speed_loop_checker.sv
// Port-level checker for the speed loop block
`timescale 1ns/1ns
module slt_speed_loop_checker (
  // Clock and reset
  input wire logic               clk_i,
  input wire logic               reset_i,
  // Watched ports
  input wire logic               zero_command_speed_mode_i,
  input wire logic               speed_select_bit0_i,
  input wire logic               speed_select_bit1_i,
  input wire logic               drive_enable_i,
  input wire logic               estimate_run_o,
  input wire logic               param_wr_i,
  input wire logic               param_rd_i,
  input wire logic [15:0]        param_addr_i,
  input wire logic [31:0]        param_wdata_i,
  input wire logic [31:0]        param_rdata_o,
  input wire logic signed [31:0] first_speed_command_o,
  input wire logic signed [31:0] speed_cmd_o,
  input wire logic signed [31:0] current_cmd_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence rd_at(logic [15:0] a);
    param_rd_i && param_addr_i == a;
  endsequence
  sequence mode_wr(logic [31:0] m);
    param_wr_i && param_addr_i == slt_pkg::OFS_TUNE_MODE && param_wdata_i == m;
  endsequence
  zero_cmd_a: assert property (zero_command_speed_mode_i |=> first_speed_command_o == 0)
    else $error("first command not zero in zero-speed mode");
  off_cmd_a: assert property (!drive_enable_i |=> speed_cmd_o == 0)
    else $error("speed command not zero while disabled");
  sel_first_a: assert property (drive_enable_i && !speed_select_bit0_i && !speed_select_bit1_i
    |=> speed_cmd_o == $past(first_speed_command_o)) else $error("select 00 missed first command");
  mode_range_a: assert property (rd_at(slt_pkg::OFS_TUNE_MODE) |=> param_rdata_o <= 32'h2)
    else $error("tuning mode out of range");
  kp_range_a: assert property (rd_at(slt_pkg::OFS_PROP_GAIN) |=> param_rdata_o <= 32'h1fff)
    else $error("proportional gain above limit");
  ki_range_a: assert property (rd_at(slt_pkg::OFS_INTEG_GAIN) |=> param_rdata_o <= 32'h3ff)
    else $error("integral gain above limit");
  manual_idle_a: assert property (mode_wr(32'h0) ##1 !param_wr_i [*2] |-> !estimate_run_o)
    else $error("estimation running in manual mode");
  est_start_a: assert property (mode_wr(32'h1) or mode_wr(32'h2) |-> ##[1:2] estimate_run_o)
    else $error("estimation not started on mode entry");
  curr_off_a: assert property (!drive_enable_i [*3] |-> current_cmd_o == 0)
    else $error("current command not zero while disabled");
endmodule : slt_speed_loop_checker

bind slt_speed_loop slt_speed_loop_checker u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .zero_command_speed_mode_i(zero_command_speed_mode_i),
  .speed_select_bit0_i(speed_select_bit0_i), .speed_select_bit1_i(speed_select_bit1_i),
  .drive_enable_i(drive_enable_i), .estimate_run_o(estimate_run_o), .param_wr_i(param_wr_i),
  .param_rd_i(param_rd_i), .param_addr_i(param_addr_i), .param_wdata_i(param_wdata_i),
  .param_rdata_o(param_rdata_o), .first_speed_command_o(first_speed_command_o),
  .speed_cmd_o(speed_cmd_o), .current_cmd_o(current_cmd_o));

// File: verification/tb.sv
// Self-checking bench for the speed loop block
`timescale 1ns/1ns
module tb;
  logic               clk_i = 1'b0;
  logic               reset_i = 1'b1;
  logic signed [15:0] ref_mv = '0, gnd_mv = '0, ref_w, gnd_w;
  logic [1:0]         sel = '0;
  logic               zero = 1'b0, en = 1'b1, sel_b0, sel_b1, zm, settled = 1'b0, oor = 1'b0, run;
  logic signed [31:0] fb = '0, first, scmd, cur, fexp;
  logic [15:0]        est = 16'h0028, addr = '0, seed = 16'h0007;
  logic               wr = 1'b0, rd = 1'b0;
  logic [31:0]        wdata = '0, rdata, got;
  int                 n_fail = 0, cmp_count = 0, fs;
  logic [15:0]        ofs [5] = '{16'h0150, 16'h0208, 16'h020c, 16'h0318, 16'h0240};
  logic [31:0]        dflt [5] = '{32'd3000, 32'd500, 32'd100, 32'd0, 32'd0};
  logic [31:0]        lim [5] = '{32'd50000, 32'd8191, 32'd1023, 32'd100, 32'd0};

  always #2 clk_i = ~clk_i;

  slt_ref_src u_src (.ref_mv_i(ref_mv), .gnd_mv_i(gnd_mv), .sel_i(sel), .zero_i(zero),
    .ref_o(ref_w), .gnd_o(gnd_w), .sel0_o(sel_b0), .sel1_o(sel_b1), .zero_o(zm));
  slt_speed_loop #(.SAVE_PERIOD_CYC(64), .CTRL_DIV(4)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
    .speed_ref_mv_i(ref_w), .analog_ground_input_i(gnd_w), .zero_command_speed_mode_i(zm),
    .speed_select_bit0_i(sel_b0), .speed_select_bit1_i(sel_b1),
    .drive_enable_i(en), .speed_fb_i(fb),
    .inertia_estimate_i(est), .inertia_settled_i(settled), .inertia_out_of_range_i(oor),
    .estimate_run_o(run), .param_wr_i(wr), .param_rd_i(rd), .param_addr_i(addr),
    .param_wdata_i(wdata), .param_rdata_o(rdata), .first_speed_command_o(first),
    .speed_cmd_o(scmd), .current_cmd_o(cur));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Auto gain from stiffness 80 and inertia e
  function automatic logic [31:0] kp_of(input int e);
    return (80 * (100 + e) / 100 > 8191) ? 32'd8191 : 32'(80 * (100 + e) / 100);
  endfunction : kp_of

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic put(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk_i);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk_i);
    wr = 1'b0;
  endtask : put
  // Read lands one cycle after the strobe edge
  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    @(negedge clk_i);
    rd = 1'b1;
    addr = a;
    @(negedge clk_i);
    rd = 1'b0;
    chk(rdata, e);
  endtask : rchk
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    #4000;
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i) reset_i = 1'b0;
    foreach (ofs[i]) begin
      rchk(ofs[i], dflt[i]);
      put(ofs[i], 32'h0000_ffff);
      rchk(ofs[i], lim[i]);
    end
    put(16'h0308, 32'h1);
    rchk(16'h0308, 32'h0);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      fs = (i == 0) ? 50000 : int'(seed) % 50001;
      put(16'h0150, 32'(fs));
      seed = lfsr(seed);
      ref_mv = (i == 0) ? 16'sd10000 : 16'(int'(seed) % 20001 - 10000);
      gnd_mv = (i == 0) ? 16'sd0 : 16'(seed[3:0]);
      zero = (i > 0) && seed[4];
      en = (i == 0) || seed[5];
      repeat (3) @(negedge clk_i);
      fexp = zero ? 32'sd0 : 32'((longint'(ref_mv) - longint'(gnd_mv)) * fs / 10000);
      chk(first, fexp);
      chk(scmd, en ? fexp : 32'sd0);
    end
    en = 1'b1;
    zero = 1'b0;
    for (int k = 1; k < 4; k++) begin
      put(16'h0320 + 16'(4 * (k - 1)), 32'(100 * k + 7));
      sel = 2'(k);
      repeat (3) @(negedge clk_i);
      chk(scmd, 32'(100 * k + 7));
    end
    sel = 2'b00;
    put(16'h0300, 32'd40);
    put(16'h0240, 32'h1);
    rchk(16'h0240, 32'h1);
    chk(32'(run), 32'h1);
    est = 16'd60;
    repeat (70) @(negedge clk_i);
    rchk(16'h0300, 32'd60);
    put(16'h0240, 32'h0);
    rchk(16'h0208, kp_of(60));
    rchk(16'h020c, kp_of(60) >> 2);
    rchk(16'h030c, 32'd20);
    rchk(16'h0300, 32'd60);
    chk(32'(run), 32'h0);
    est = 16'd70;
    put(16'h0240, 32'h2);
    chk(32'(run), 32'h1);
    settled = 1'b1;
    rchk(16'h0308, 32'h1);
    chk(32'(run), 32'h0);
    oor = 1'b1;
    rchk(16'h0308, 32'h0);
    chk(32'(run), 32'h1);
    oor = 1'b0;
    rchk(16'h0308, 32'h1);
    put(16'h0240, 32'h0);
    rchk(16'h0310, 32'd5);
    rchk(16'h0314, 32'd50);
    rchk(16'h0208, kp_of(70));
    put(16'h0208, 32'd1024);
    put(16'h020c, 32'd0);
    put(16'h0318, 32'd50);
    put(16'h0150, 32'd3000);
    ref_mv = 16'sd5000;
    gnd_mv = 16'sd0;
    fb = 32'sd1000;
    repeat (20) @(negedge clk_i);
    chk(cur, 32'sd1250);
    en = 1'b0;
    repeat (5) @(negedge clk_i);
    chk(cur, 32'sd0);
    stop_test();
  end
endmodule : tb
